// [dv/serial_host_model.sv]
`timescale 1ns/100ps
// serial bus master: clock idles low and runs only inside 24-bit frames
module serial_host_model (
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic serial_out_with_ready,
	input wire logic serial_out_oe
);
	realtime last_fall; // time of the last falling clock of a frame
	int oe_miss; // bits sampled while the device output was disabled
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b1;
		last_fall = 0.0;
		oe_miss = 0;
	end
	// full duplex: command bits go out while result bits come back
	task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
		rx = 24'h00_0000;
		cs_n = 1'b0;
		#125;
		for (int i = 23; i >= 0; i--) begin
			sclk = 1'b1; // device launches its bit here
			din = tx[i];
			#62.5;
			sclk = 1'b0; // both sides sample here
			rx[i] = serial_out_with_ready;
			if (serial_out_oe !== 1'b1) begin
				oe_miss++;
			end
			last_fall = $realtime;
			#62.5;
		end
		cs_n = 1'b1;
		// released line shows the inverse so a stale level never passes
		din = ~din;
	endtask
endmodule

// [dv/tb.sv]
`timescale 1ns/100ps
module tb;
	typedef logic [19:0] len_arr_type [10];
	// short conversion lengths keep the run brief; base plus rate index
	function automatic len_arr_type mk(input logic [19:0] base);
		for (int i = 0; i < 10; i++) begin
			mk[i] = base + 20'(i);
		end
	endfunction
	localparam len_arr_type FS = mk(20'h0_0014);
	localparam len_arr_type FL = mk(20'h0_0028);
	localparam len_arr_type ST = mk(20'h0_000a);
	localparam logic [7:0] RESYNC = 8'h01; // arbitrary command code
	logic core_clk, rst, reset_pin_n, start_pin, cmd_reset, cmd_leave_sleep;
	logic wr_input_select, wr_bias, wr_ref_mux, wr_gain_rate, mod_tick;
	logic [3:0] rate_sel;
	logic signed [27:0] filter_sum;
	logic sclk, cs_n, din, serial_out_with_ready, serial_out_oe;
	logic result_ready_n, filter_reset_n, result_valid;
	logic [23:0] result_word, rx;
	logic [1:0] tick_cnt; // modulator tick divider, one tick in four
	int bad_count, checks_done;
	adc_filter_ctrl #(.FIRST_SHORT(FS), .FIRST_LONG(FL), .STEADY(ST),
		.RESYNC_CODE(RESYNC)) u_adc_filter_ctrl (.core_clk(core_clk),
		.rst(rst), .reset_pin_n(reset_pin_n), .start_pin(start_pin),
		.cmd_reset(cmd_reset), .cmd_leave_sleep(cmd_leave_sleep),
		.wr_input_select(wr_input_select), .wr_bias(wr_bias),
		.wr_ref_mux(wr_ref_mux), .wr_gain_rate(wr_gain_rate),
		.mod_tick(mod_tick), .rate_sel(rate_sel), .filter_sum(filter_sum),
		.sclk(sclk), .cs_n(cs_n), .din(din),
		.serial_out_with_ready(serial_out_with_ready),
		.serial_out_oe(serial_out_oe), .result_ready_n(result_ready_n),
		.filter_reset_n(filter_reset_n), .result_valid(result_valid),
		.result_word(result_word));
	serial_host_model u_serial_host_model (.sclk(sclk), .cs_n(cs_n),
		.din(din), .serial_out_with_ready(serial_out_with_ready),
		.serial_out_oe(serial_out_oe));
	// system clock, 20 ns
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// modulator tick every fourth system clock
	always @(posedge core_clk) begin
		tick_cnt <= tick_cnt + 2'h1;
		mod_tick <= (tick_cnt == 2'h2);
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("mismatches %0d of %0d compares", bad_count, checks_done);
		if (bad_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// wait for the filter reset level, counting cycles; bounded
	task automatic wait_frn(input logic v, output int n);
		n = 0;
		#1;
		while (filter_reset_n !== v && n < 2000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check(32'(n < 2000), 32'd1);
	endtask
	// cycles from now up to the next result pulse; bounded
	task automatic wait_valid(output int n);
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (result_valid !== 1'b1 && n < 2000);
	endtask
	// one-cycle strobe for sources 0 to 5, start pin raised for 6, resync frame for 7; -1 only clears the strobes
	task automatic pulse(input int src);
		@(posedge core_clk);
		// each strobe is written once per edge: high for its source only
		wr_input_select <= (src == 0);
		wr_bias <= (src == 1);
		wr_ref_mux <= (src == 2);
		wr_gain_rate <= (src == 3);
		cmd_reset <= (src == 4);
		cmd_leave_sleep <= (src == 5);
		if (src == 6) begin
			start_pin <= 1'b1;
		end
		if (src == 7) begin
			fork
				u_serial_host_model.frame({16'h0000, RESYNC}, rx);
			join_none
		end
	endtask
	// fire one or two sources, then time the reset and two conversions
	task automatic conv_run(input int src, input int src2,
		input logic [3:0] rate, input logic lng);
		int n;
		int idx;
		idx = (rate > 4'h9) ? 9 : int'(rate);
		@(posedge core_clk);
		rate_sel <= rate;
		pulse(src);
		if (src2 >= 0) begin
			pulse(src2);
		end
		pulse(-1);
		wait_frn(1'b0, n);
		if (src == 7) begin
			check(32'($realtime - u_serial_host_model.last_fall < 100.0),
				32'd1);
		end
		wait_frn(1'b1, n);
		if (lng) begin
			check(32'(n >= 124 && n <= 136), 32'd1);
		end else begin
			check(32'(n), 32'd2);
		end
		wait_valid(n);
		check(32'(n), 32'(lng ? FL[idx] : FS[idx]));
		wait_valid(n);
		check(32'(n), 32'(ST[idx]));
		@(posedge core_clk);
		start_pin <= 1'b0;
	endtask
	// hold a raw filter value and compare the coded result
	task automatic clip(input logic signed [27:0] sum, input logic [23:0] e);
		int n;
		@(posedge core_clk);
		filter_sum <= sum;
		wait_valid(n);
		wait_valid(n);
		check(32'(result_word), 32'(e));
	endtask
	// reset pin holds the filter while the host reads the last result
	task automatic pin_read();
		int n;
		clip(28'sh012_3456, 24'h12_3456);
		@(posedge core_clk);
		reset_pin_n <= 1'b0;
		wait_frn(1'b0, n);
		repeat (5) @(posedge core_clk);
		#1;
		check(32'(result_ready_n), 32'd0);
		check(32'({serial_out_oe, serial_out_with_ready}), 32'd0);
		u_serial_host_model.frame(24'h00_0000, rx);
		repeat (6) @(posedge core_clk);
		#1;
		check(32'(rx), 32'h0012_3456);
		check(32'(result_ready_n), 32'd1);
		check(32'(serial_out_oe), 32'd0);
		check(32'(u_serial_host_model.oe_miss), 32'd0);
		check(32'(filter_reset_n), 32'd0);
		@(posedge core_clk);
		reset_pin_n <= 1'b1;
		wait_frn(1'b1, n);
		check(32'(n >= 124 && n <= 140), 32'd1);
		wait_valid(n);
		check(32'(n), 32'(FL[2]));
	endtask
	// watchdog, well beyond the expected few thousand cycles
	initial begin
		repeat (40000) @(posedge core_clk);
		bad_count++;
		$display("ERROR %0t: watchdog expired", $time);
		final_report();
	end
	initial begin
		{rst, reset_pin_n, start_pin, cmd_reset, cmd_leave_sleep} = 5'h18;
		{wr_input_select, wr_bias, wr_ref_mux, wr_gain_rate} = 4'h0;
		{mod_tick, tick_cnt} = 3'h0;
		rate_sel = 4'h2;
		filter_sum = 28'sh000_0000;
		{bad_count, checks_done} = 0;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		repeat (3) @(posedge core_clk);
		for (int r = 0; r < 10; r++) begin
			conv_run(0, -1, 4'(r), 1'b0);
		end
		conv_run(0, -1, 4'hf, 1'b0);
		for (int s = 1; s < 7; s++) begin
			conv_run(s, -1, 4'(s), 1'b1);
		end
		conv_run(7, -1, 4'h3, 1'b0);
		conv_run(0, 1, 4'h2, 1'b1);
		clip(28'sh000_0000, 24'h00_0000);
		clip(28'sh000_0001, 24'h00_0001);
		clip(-28'sh000_0001, 24'hff_ffff);
		clip(28'sh07f_ffff, 24'h7f_ffff);
		clip(28'sh100_0000, 24'h7f_ffff);
		clip(28'shf80_0000, 24'h80_0000);
		clip(28'sh800_0000, 24'h80_0000);
		pin_read();
		final_report();
	end
endmodule

// [rtl/adc_ctrl_pkg.sv]
package adc_ctrl_pkg;
	// number of selectable output data rates
	localparam int RATE_COUNT = 10;
	// width of conversion counters and of the raw filter sum
	localparam int CONV_W = 20;
	localparam int FILT_W = 28;
	// filter reset pulse lengths
	localparam logic [1:0] SHORT_RST_CYC = 2'h2;
	localparam logic [5:0] LONG_RST_MOD = 6'h20;
	// output code limits and raw-sum clip thresholds
	localparam logic [23:0] CODE_MAX = 24'h7f_ffff;
	localparam logic [23:0] CODE_MIN = 24'h80_0000;
	localparam logic signed [27:0] RAW_MAX = 28'sh07f_ffff;
	localparam logic signed [27:0] RAW_MIN = 28'shf80_0000;
	// reset value of the pin synchronisers: pin_n, start, cs_n, two toggles
	localparam logic [4:0] SYNC_RST = 5'h14;
	// first conversion after a resync or input-select reset
	localparam logic [19:0] FIRST_SHORT_CYC [RATE_COUNT] = '{
		20'hc_743c, 20'h6_3a3c, 20'h3_1d3c, 20'h1_8ebc, 20'h0_c77c,
		20'h0_63dc, 20'h0_31fc, 20'h0_191c, 20'h0_103c, 20'h0_083c};
	// first conversion after any other reset source
	localparam logic [19:0] FIRST_LONG_CYC [RATE_COUNT] = '{
		20'hc_8442, 20'h6_4a42, 20'h3_2d42, 20'h1_92c2, 20'h0_cb82,
		20'h0_67e2, 20'h0_3402, 20'h0_1b22, 20'h0_1242, 20'h0_0942};
	// second and later conversions
	localparam logic [19:0] STEADY_CYC [RATE_COUNT] = '{
		20'hc_7400, 20'h6_3a00, 20'h3_1d00, 20'h1_8e80, 20'h0_c740,
		20'h0_63a0, 20'h0_31c0, 20'h0_18e0, 20'h0_1000, 20'h0_0800};
	// which length table applies
	localparam logic [1:0] LEN_SHORT = 2'h0;
	localparam logic [1:0] LEN_LONG = 2'h1;
	localparam logic [1:0] LEN_STEADY = 2'h2;
	// kind of the reset that started the current conversion sequence
	typedef enum logic {KIND_SHORT = 1'b0, KIND_LONG = 1'b1} kind_type;
	// conversion engine state
	typedef enum logic {ST_HOLD = 1'b0, ST_RUN = 1'b1} conv_state_type;
endpackage

// [rtl/adc_filter_ctrl.sv]
`timescale 1ns/100ps
// Behaviour
// - many events reset the decimation filter
// - resync gives two-clock reset, three clocks after command
// - input-select write gives two-clock reset
// - bias/ref/gain write gives 32-modulator-tick reset
// - reset pulses combine, any one holds reset
// - first conversion length after short-kind reset
// - first conversion length after long-kind reset
// - later conversions use steady length
// - result is 24-bit two's complement
// - result saturates at both full scales
// - deselect tristates output, resets serial receiver and transmitter
// - deselect stops only serial traffic
// - port is full duplex with read exceptions
// - sample on falling, launch on rising
// - ready falls on result, rises on clock
module adc_filter_ctrl #(
	parameter logic [19:0] FIRST_SHORT [10] = adc_ctrl_pkg::FIRST_SHORT_CYC,
	parameter logic [19:0] FIRST_LONG [10] = adc_ctrl_pkg::FIRST_LONG_CYC,
	parameter logic [19:0] STEADY [10] = adc_ctrl_pkg::STEADY_CYC,
	parameter logic [7:0] RESYNC_CODE = 8'h01
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic reset_pin_n,
	input wire logic start_pin,
	input wire logic cmd_reset,
	input wire logic cmd_leave_sleep,
	input wire logic wr_input_select,
	input wire logic wr_bias,
	input wire logic wr_ref_mux,
	input wire logic wr_gain_rate,
	input wire logic mod_tick,
	input wire logic [3:0] rate_sel,
	input wire logic signed [27:0] filter_sum,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic serial_out_with_ready,
	output logic serial_out_oe,
	output logic result_ready_n,
	output logic filter_reset_n,
	output logic result_valid,
	output logic [23:0] result_word
);
	adc_link lnk();

	// serial port on the link clock
	adc_serial_port #(.RESYNC_CODE(RESYNC_CODE)) u_port (
		.sclk(sclk),
		.cs_n(cs_n),
		.rst(rst),
		.din(din),
		.serial_out(serial_out_with_ready),
		.link(lnk.port)
	);

	// conversion length for a rate index and a table choice
	function automatic logic [19:0] conv_len(input logic [3:0] idx,
		input logic [1:0] sel);
		logic [19:0] len;
		case (sel)
			adc_ctrl_pkg::LEN_SHORT: len = FIRST_SHORT[idx];
			adc_ctrl_pkg::LEN_LONG: len = FIRST_LONG[idx];
			default: len = STEADY[idx];
		endcase
		return len;
	endfunction

	// clip the wide filter sum into the 24-bit output code
	function automatic logic [23:0] clip(input logic signed [27:0] v);
		logic [23:0] c;
		if (v > adc_ctrl_pkg::RAW_MAX) begin
			c = adc_ctrl_pkg::CODE_MAX;
		end else if (v < adc_ctrl_pkg::RAW_MIN) begin
			c = adc_ctrl_pkg::CODE_MIN;
		end else begin
			c = v[23:0];
		end
		return c;
	endfunction

	logic [4:0] meta_reg; // first stage, read only by sync_reg
	logic [4:0] sync_reg; // pin_n, start, cs_n, resync, fall
	logic [2:0] last_reg; // previous start, resync, fall
	logic [4:0] meta_next;
	logic [2:0] last_next;
	logic pin_low;
	logic start_rise;
	logic resync_ev;
	logic fall_ev;
	logic [3:0] rate_idx; // rate clamped to the table
	logic short_src;
	logic long_src;
	logic [1:0] short_cnt_reg; // core clocks left of short pulse
	logic [1:0] short_cnt_next;
	logic [5:0] long_cnt_reg; // modulator ticks left of long pulse
	logic [5:0] long_cnt_next;
	logic filt_n_next;
	adc_ctrl_pkg::kind_type kind_reg;
	adc_ctrl_pkg::kind_type kind_next;
	adc_ctrl_pkg::conv_state_type state_reg;
	adc_ctrl_pkg::conv_state_type state_next;
	logic [19:0] conv_cnt_reg; // cycles left in this conversion
	logic [19:0] conv_cnt_next;
	logic conv_done;
	logic [23:0] word_next;
	logic valid_next;
	logic ready_next;
	logic pend_reg; // ready was low at the last result: pulse it
	logic pend_next;
	logic oe_next;

	// pins and link toggles pass two flops before anything reads them
	always_comb begin
		meta_next = {reset_pin_n, start_pin, cs_n, lnk.resync_tgl,
			lnk.fall_tgl};
		last_next = {sync_reg[3], sync_reg[1], sync_reg[0]};
		pin_low = ~sync_reg[4];
		start_rise = sync_reg[3] & ~last_reg[2];
		resync_ev = sync_reg[1] ^ last_reg[1];
		fall_ev = sync_reg[0] ^ last_reg[0];
		rate_idx = (rate_sel > 4'h9) ? 4'h9 : rate_sel;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_reg <= adc_ctrl_pkg::SYNC_RST;
			sync_reg <= adc_ctrl_pkg::SYNC_RST;
			last_reg <= 3'h0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= meta_reg;
			last_reg <= last_next;
		end
	end

	// filter reset sources: short ones count core clocks, long ones
	// count modulator ticks; the reset pin holds the long count full
	always_comb begin
		short_src = wr_input_select | resync_ev;
		long_src = cmd_reset | cmd_leave_sleep | wr_bias | wr_ref_mux |
			wr_gain_rate | start_rise | pin_low;
		short_cnt_next = short_cnt_reg;
		if (short_src) begin
			short_cnt_next = adc_ctrl_pkg::SHORT_RST_CYC;
		end else if (short_cnt_reg != 2'h0) begin
			short_cnt_next = short_cnt_reg - 2'h1;
		end
		long_cnt_next = long_cnt_reg;
		if (long_src) begin
			long_cnt_next = adc_ctrl_pkg::LONG_RST_MOD;
		end else if (mod_tick && long_cnt_reg != 6'h00) begin
			long_cnt_next = long_cnt_reg - 6'h01;
		end
		// active-low pulses are ANDed, so any active one holds reset
		filt_n_next = (short_cnt_next == 2'h0) &&
			(long_cnt_next == 6'h00) && !pin_low;
		// a long source anywhere in the window decides the first length
		kind_next = kind_reg;
		if (long_src) begin
			kind_next = adc_ctrl_pkg::KIND_LONG;
		end else if (short_src && long_cnt_reg == 6'h00) begin
			kind_next = adc_ctrl_pkg::KIND_SHORT;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			short_cnt_reg <= 2'h0;
			long_cnt_reg <= 6'h00;
			filter_reset_n <= 1'b0;
			kind_reg <= adc_ctrl_pkg::KIND_LONG;
		end else begin
			short_cnt_reg <= short_cnt_next;
			long_cnt_reg <= long_cnt_next;
			filter_reset_n <= filt_n_next;
			kind_reg <= kind_next;
		end
	end

	// conversion timer: runs regardless of chip select
	always_comb begin
		state_next = state_reg;
		conv_cnt_next = conv_cnt_reg;
		conv_done = 1'b0;
		case (state_reg)
			adc_ctrl_pkg::ST_HOLD: begin
				// preload the first length while the filter is held
				conv_cnt_next = conv_len(rate_idx,
					(kind_next == adc_ctrl_pkg::KIND_LONG) ?
					adc_ctrl_pkg::LEN_LONG :
					adc_ctrl_pkg::LEN_SHORT) - 20'h0_0001;
				if (filt_n_next) begin
					state_next = adc_ctrl_pkg::ST_RUN;
				end
			end
			adc_ctrl_pkg::ST_RUN: begin
				if (!filt_n_next) begin
					state_next = adc_ctrl_pkg::ST_HOLD;
				end else if (conv_cnt_reg == 20'h0_0000) begin
					conv_done = 1'b1;
					conv_cnt_next = conv_len(rate_idx,
						adc_ctrl_pkg::LEN_STEADY) - 20'h0_0001;
				end else begin
					conv_cnt_next = conv_cnt_reg - 20'h0_0001;
				end
			end
			default: begin
				state_next = adc_ctrl_pkg::ST_HOLD;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= adc_ctrl_pkg::ST_HOLD;
			conv_cnt_reg <= 20'h0_0000;
		end else begin
			state_reg <= state_next;
			conv_cnt_reg <= conv_cnt_next;
		end
	end

	// result word and ready line; ready may be polled while deselected
	always_comb begin
		word_next = result_word;
		valid_next = conv_done;
		ready_next = result_ready_n;
		pend_next = 1'b0;
		if (conv_done) begin
			word_next = clip(filter_sum);
			if (!result_ready_n) begin
				ready_next = 1'b1;
				pend_next = 1'b1;
			end else begin
				ready_next = 1'b0;
			end
		end else if (pend_reg) begin
			ready_next = 1'b0;
		end else if (fall_ev) begin
			ready_next = 1'b1;
		end
		oe_next = ~sync_reg[2];
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			result_word <= 24'h00_0000;
			result_valid <= 1'b0;
			result_ready_n <= 1'b1;
			pend_reg <= 1'b0;
			serial_out_oe <= 1'b0;
		end else begin
			result_word <= word_next;
			result_valid <= valid_next;
			result_ready_n <= ready_next;
			pend_reg <= pend_next;
			serial_out_oe <= oe_next;
		end
	end

	// the port samples this word at its first launch; a read begun
	// within a few core clocks of ready falling may see a torn word
	assign lnk.snap_word = result_word;

	property p_resync_reset;
		@(posedge core_clk) disable iff (rst)
		(sync_reg[1] != last_reg[1]) |=> !filter_reset_n [*2];
	endproperty
	a_resync_reset: assert property (p_resync_reset)
		else $error("resync did not reset the filter");

	property p_short_pulse;
		@(posedge core_clk) disable iff (rst)
		(wr_input_select && !long_src && long_cnt_reg == 6'h00) ##1
		(!short_src && !long_src) [*2] |-> !filter_reset_n ##1
		filter_reset_n;
	endproperty
	a_short_pulse: assert property (p_short_pulse)
		else $error("input-select reset not two clocks long");

	property p_long_pulse;
		@(posedge core_clk) disable iff (rst)
		(wr_bias || wr_ref_mux || wr_gain_rate) |=>
		(long_cnt_reg == adc_ctrl_pkg::LONG_RST_MOD) && !filter_reset_n;
	endproperty
	a_long_pulse: assert property (p_long_pulse)
		else $error("register write did not start long reset");

	property p_and_reset;
		@(posedge core_clk) disable iff (rst)
		(short_cnt_reg != 2'h0 || long_cnt_reg != 6'h00 || $past(pin_low))
		|-> !filter_reset_n;
	endproperty
	a_and_reset: assert property (p_and_reset)
		else $error("filter released while a reset pulse active");

	property p_first_short;
		@(posedge core_clk) disable iff (rst)
		$rose(filter_reset_n) && kind_reg == adc_ctrl_pkg::KIND_SHORT
		|-> conv_cnt_reg == conv_len($past(rate_idx),
			adc_ctrl_pkg::LEN_SHORT) - 20'h0_0001;
	endproperty
	a_first_short: assert property (p_first_short)
		else $error("wrong first length after short reset");

	property p_first_long;
		@(posedge core_clk) disable iff (rst)
		$rose(filter_reset_n) && kind_reg == adc_ctrl_pkg::KIND_LONG
		|-> conv_cnt_reg == conv_len($past(rate_idx),
			adc_ctrl_pkg::LEN_LONG) - 20'h0_0001;
	endproperty
	a_first_long: assert property (p_first_long)
		else $error("wrong first length after long reset");

	property p_steady;
		@(posedge core_clk) disable iff (rst)
		conv_done && filt_n_next |=> conv_cnt_reg ==
			conv_len($past(rate_idx), adc_ctrl_pkg::LEN_STEADY) -
			20'h0_0001;
	endproperty
	a_steady: assert property (p_steady)
		else $error("wrong steady conversion length");

	property p_code_pass;
		@(posedge core_clk) disable iff (rst)
		conv_done && filter_sum <= adc_ctrl_pkg::RAW_MAX &&
		filter_sum >= adc_ctrl_pkg::RAW_MIN
		|=> result_valid && result_word == $past(filter_sum[23:0]);
	endproperty
	a_code_pass: assert property (p_code_pass)
		else $error("in-range result not passed through");

	property p_clip;
		@(posedge core_clk) disable iff (rst)
		conv_done && filter_sum > adc_ctrl_pkg::RAW_MAX
		|=> result_word == adc_ctrl_pkg::CODE_MAX;
	endproperty
	a_clip: assert property (p_clip)
		else $error("positive overrange not clipped");

	property p_oe_off;
		@(posedge core_clk) disable iff (rst)
		sync_reg[2] |=> !serial_out_oe;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("output driven while deselected");

	property p_ready_pulse;
		@(posedge core_clk) disable iff (rst)
		conv_done && !result_ready_n |=> result_ready_n ##1
			!result_ready_n;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("ready did not pulse before new result");
endmodule

// [rtl/adc_link_if.sv]
`timescale 1ns/100ps
// signals between the serial port (serial clock) and the core clock logic
interface adc_link;
	logic resync_tgl; // flips once per received resync command
	logic fall_tgl; // flips on every falling serial clock edge
	logic [23:0] snap_word; // latest result, quasi-static for the port
	modport port(output resync_tgl, output fall_tgl, input snap_word);
	modport core(input resync_tgl, input fall_tgl, output snap_word);
endinterface

// [rtl/adc_serial_port.sv]
`timescale 1ns/100ps
module adc_serial_port #(
	parameter logic [7:0] RESYNC_CODE = 8'h01
) (
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic rst,
	input wire logic din,
	output logic serial_out,
	adc_link.port link
);
	logic [2:0] bit_cnt_reg; // bits received in the current byte
	logic [2:0] bit_cnt_next;
	logic [6:0] rx_reg; // first seven bits of the byte
	logic [6:0] rx_next;
	logic cmd_hit; // byte just completed is a resync command
	logic resync_tgl_reg;
	logic resync_tgl_next;
	logic fall_tgl_reg;
	logic fall_tgl_next;
	logic first_reg; // no bit launched yet in this selection
	logic first_next;
	logic [23:0] tx_reg; // output shifter
	logic [23:0] tx_next;
	logic out_reg;
	logic out_next;

	// receive side: input bits are taken on the falling edge
	always_comb begin
		bit_cnt_next = bit_cnt_reg + 3'h1;
		rx_next = {rx_reg[5:0], din};
		cmd_hit = (bit_cnt_reg == 3'h7) && ({rx_reg, din} == RESYNC_CODE);
	end

	// deselect holds the receiver in reset, so stray clocks are ignored
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt_reg <= 3'h0;
			rx_reg <= 7'h00;
		end else begin
			bit_cnt_reg <= bit_cnt_next;
			rx_reg <= rx_next;
		end
	end

	// event toggles live outside the chip-select reset: a reset there
	// could flip them and fake an event on the core side
	always_comb begin
		resync_tgl_next = resync_tgl_reg ^ cmd_hit;
		fall_tgl_next = ~fall_tgl_reg;
	end

	always_ff @(negedge sclk or posedge rst) begin
		if (rst) begin
			resync_tgl_reg <= 1'b0;
			fall_tgl_reg <= 1'b0;
		end else begin
			resync_tgl_reg <= resync_tgl_next;
			fall_tgl_reg <= fall_tgl_next;
		end
	end

	assign link.resync_tgl = resync_tgl_reg;
	assign link.fall_tgl = fall_tgl_reg;

	// transmit side: result goes out msb first on rising edges while
	// commands keep arriving on the other line
	always_comb begin
		first_next = 1'b0;
		if (first_reg) begin
			out_next = link.snap_word[23];
			tx_next = {link.snap_word[22:0], 1'b0};
		end else begin
			out_next = tx_reg[23];
			tx_next = {tx_reg[22:0], 1'b0};
		end
	end

	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			first_reg <= 1'b1;
			tx_reg <= 24'h00_0000;
			out_reg <= 1'b0;
		end else begin
			first_reg <= first_next;
			tx_reg <= tx_next;
			out_reg <= out_next;
		end
	end

	assign serial_out = out_reg;
endmodule
